//--- bench/bfm_exec_checker.sv
`timescale 1ns/1ps
module bfm_exec_checker (
    input wire clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire mem_rd,
    input wire busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire acc = psel && penable;
    wire bad = paddr[1:0] != 2'h0 || paddr > 8'h0c;
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err; acc && bad |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no slave error");
    property p_noerr; acc && !bad |-> !pslverr; endproperty
    a_noerr: assert property (p_noerr) else $error("false slave error");
    property p_start; acc && pwrite && paddr == 8'h00 && !busy |=> busy; endproperty
    a_start: assert property (p_start) else $error("command not started");
    property p_one; $rose(busy) && !mem_rd |=> !busy; endproperty
    a_one: assert property (p_one) else $error("op not single cycle");
    property p_pulse; mem_rd |=> !mem_rd; endproperty
    a_pulse: assert property (p_pulse) else $error("read strobe too long");
    property p_two; mem_rd |-> busy ##1 busy ##1 !busy; endproperty
    a_two: assert property (p_two) else $error("load not two cycles");
    property p_ends; $rose(busy) |-> ##[1:2] !busy; endproperty
    a_ends: assert property (p_ends) else $error("op overran");
endmodule
bind bfm_exec bfm_exec_checker i_bfm_exec_checker (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .mem_rd(mem_rd), .busy(busy));

//--- bench/bfm_exec_tb.sv
`timescale 1ns/1ps
module bfm_exec_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire pready, pslverr, mem_rd, busy;
    wire [31:0] prdata;
    wire [15:0] mem_addr;
    wire [7:0] mem_rdata;
    int fails = 0;
    int checks_done = 0;
    int bpos[7] = '{0, 2, 1, 4, 3, 6, 5};
    logic [31:0] rv;
    logic er;
    initial forever #5 clk = ~clk;
    bfm_exec i_bfm_exec (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
        .busy(busy));
    bfm_mem_model i_bfm_mem_model (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata));
    task automatic chk(input [7:0] got, input [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input w, input [7:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setr(input [4:0] i, input [7:0] v);
        apb(1, 8'h08, {27'h0, i});
        apb(1, 8'h0c, {24'h0, v});
    endtask
    task automatic expr(input [4:0] i, input [7:0] v);
        apb(1, 8'h08, {27'h0, i});
        apb(0, 8'h0c, 32'h0);
        chk(rv[7:0], v);
    endtask
    task automatic expf(input [7:0] v);
        apb(0, 8'h04, 32'h0);
        chk(rv[7:0], v);
    endtask
    task automatic run(input [5:0] op, input [4:0] rd, input [4:0] rr, input [2:0] b);
        apb(1, 8'h00, {5'h0, b, 3'h0, rr, 3'h0, rd, 2'h0, op});
        // poll busy; the watchdog bounds this
        do apb(0, 8'h04, 32'h0); while (rv[8] !== 1'b0);
        $display("test op %h done", op);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #50000;
        fails++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        expf(8'h00);
        setr(1, 8'h81);
        apb(1, 8'h04, 32'h71);
        run(6'h01, 1, 0, 0);
        expr(1, 8'h03);
        expf(8'h79);
        setr(2, 8'h01);
        apb(1, 8'h04, 32'h10);
        run(6'h02, 2, 0, 0);
        expr(2, 8'h00);
        expf(8'h1b);
        setr(3, 8'h81);
        apb(1, 8'h04, 32'h00);
        run(6'h03, 3, 0, 0);
        expr(3, 8'hc0);
        expf(8'h05);
        setr(4, 8'h3c);
        apb(1, 8'h04, 32'h5a);
        run(6'h04, 4, 0, 0);
        expr(4, 8'hc3);
        expf(8'h5a);
        setr(5, 8'h08);
        apb(1, 8'h04, 32'h00);
        run(6'h05, 5, 0, 3);
        expf(8'h40);
        setr(6, 8'h00);
        run(6'h06, 6, 0, 7);
        expr(6, 8'h80);
        expf(8'h40);
        for (int k = 0; k < 7; k++) begin
            apb(1, 8'h04, 32'h00);
            run(6'h07 + 6'(2 * k), 0, 0, 0);
            expf(8'h01 << bpos[k]);
            apb(1, 8'h04, 32'hff);
            run(6'h08 + 6'(2 * k), 0, 0, 0);
            expf(~(8'h01 << bpos[k]));
        end
        setr(7, 8'ha5);
        apb(1, 8'h04, 32'h3f);
        run(6'h15, 8, 7, 0);
        expr(8, 8'ha5);
        setr(10, 8'h12);
        setr(11, 8'h34);
        run(6'h16, 12, 10, 0);
        expr(12, 8'h12);
        expr(13, 8'h34);
        setr(26, 8'h10);
        setr(27, 8'h00);
        run(6'h17, 9, 0, 0);
        expr(9, 8'h4a);
        setr(9, 8'h00);
        run(6'h18, 9, 0, 0);
        expr(9, 8'h4a);
        expr(26, 8'h11);
        expr(27, 8'h00);
        expf(8'h3f);
        apb(0, 8'h10, 32'h0);
        chk({7'h0, er}, 8'h01);
        tally_and_finish;
    end
endmodule

//--- bench/bfm_mem_model.sv
`timescale 1ns/1ps
module bfm_mem_model (
    input wire clk,
    input wire [15:0] mem_addr,
    input wire mem_rd,
    output wire [7:0] mem_rdata
);
    logic was_rd = 1'b0;
    logic [15:0] a_q = 16'h0000;
    logic [7:0] junk = 8'h00;
    // data held through strobe cycle and the next; garbage otherwise
    always @(posedge clk) begin
        was_rd <= mem_rd;
        junk <= ~junk + 8'h01;
        if (mem_rd)
            a_q <= mem_addr;
    end
    assign mem_rdata = mem_rd ? mem_addr[7:0] ^ 8'h5a : was_rd ? a_q[7:0] ^ 8'h5a : junk;
endmodule

//--- common/bfm_exec_map.vh
`ifndef BFM_EXEC_MAP_VH
`define BFM_EXEC_MAP_VH
// apb byte offsets
`define BFM_CMD_OFS 8'h00
`define BFM_FLAGS_OFS 8'h04
`define BFM_SEL_OFS 8'h08
`define BFM_DATA_OFS 8'h0c
// command register fields
`define BFM_CMD_OP 5:0
`define BFM_CMD_RD 12:8
`define BFM_CMD_RR 20:16
`define BFM_CMD_BIT 26:24
// status flag positions
`define BFM_F_C 0
`define BFM_F_Z 1
`define BFM_F_N 2
`define BFM_F_V 3
`define BFM_F_S 4
`define BFM_F_H 5
`define BFM_F_T 6
`define BFM_F_I 7
`define BFM_FLAGS_RST 8'h00
`define BFM_BUSY_BIT 8
// operation codes
`define BFM_OP_NOP 6'h00
`define BFM_OP_ROTL 6'h01
`define BFM_OP_ROTR 6'h02
`define BFM_OP_ASHR 6'h03
`define BFM_OP_SWAP 6'h04
`define BFM_OP_BIT_TO_T 6'h05
`define BFM_OP_T_TO_BIT 6'h06
`define BFM_OP_SET_C 6'h07
`define BFM_OP_CLR_C 6'h08
`define BFM_OP_SET_N 6'h09
`define BFM_OP_CLR_N 6'h0a
`define BFM_OP_SET_Z 6'h0b
`define BFM_OP_CLR_Z 6'h0c
`define BFM_OP_SET_S 6'h0d
`define BFM_OP_CLR_S 6'h0e
`define BFM_OP_SET_V 6'h0f
`define BFM_OP_CLR_V 6'h10
`define BFM_OP_SET_T 6'h11
`define BFM_OP_CLR_T 6'h12
`define BFM_OP_SET_H 6'h13
`define BFM_OP_CLR_H 6'h14
`define BFM_OP_COPY 6'h15
`define BFM_OP_PAIR_COPY 6'h16
`define BFM_OP_LDX 6'h17
`define BFM_OP_LDXI 6'h18
// x pointer lives in this register pair
`define BFM_XL 5'h1a
`define BFM_XH 5'h1b
`endif

//--- hdl/bfm_exec.v
// Operation
// - rotate left through carry puts old carry in bit 0, old bit 7 in carry, sets Z C N V.
// - rotate right through carry puts old carry in bit 7, old bit 0 in carry, sets Z C N V.
// - arithmetic shift right moves bits down one place keeping bit 7, sets Z C N V.
// - nibble exchange swaps the register halves in one cycle with no flag change.
// - bit store copies the chosen register bit into T, changing only T.
// - bit load writes T into the chosen register bit, leaving all else alone.
// - single ops set or clear C, N, Z, S, V or T, each touching only its flag.
// - single ops set or clear H, touching no other flag.
// - register copy moves one register to another in one cycle, flags kept.
// - pair copy moves an even/odd register pair in one cycle, flags kept.
// - load through X reads memory into a register in two cycles, post-inc form bumps X.
`timescale 1ns/1ps
`include "bfm_exec_map.vh"
module bfm_exec #(
    parameter ADDR_W = 16
) (
    input wire clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    output reg [ADDR_W-1:0] mem_addr,
    output reg mem_rd,
    input wire [7:0] mem_rdata,
    output wire busy
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 2'h0;
localparam ST_EXEC = 2'h1;
localparam ST_LOAD = 2'h2;

reg rst_meta_reg;
reg rst_sync_reg;
wire rst_n;

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        rst_meta_reg <= 1'b0;
        rst_sync_reg <= 1'b0;
    end else begin
        rst_meta_reg <= 1'b1;
        rst_sync_reg <= rst_meta_reg;
    end
end
assign rst_n = rst_sync_reg;

////////////////////////////////////////////////////////////////////////////////
reg [7:0] gpr [0:31];
reg [7:0] flags_reg;
reg [7:0] flags_next;
reg [1:0] state_reg;
reg [5:0] op_reg;
reg [4:0] rd_reg;
reg [4:0] rr_reg;
reg [2:0] bit_reg;
reg [4:0] sel_reg;

wire setup = psel && !penable;
wire wr_acc = psel && penable && pwrite;
wire idle = (state_reg == ST_IDLE);
wire cmd_wr = wr_acc && (paddr == `BFM_CMD_OFS) && idle;
wire [5:0] cmd_op = pwdata[`BFM_CMD_OP];
wire cmd_load = (cmd_op == `BFM_OP_LDX) || (cmd_op == `BFM_OP_LDXI);
wire [15:0] x_ptr = {gpr[`BFM_XH], gpr[`BFM_XL]};
wire [15:0] x_inc = x_ptr + 16'h0001;

assign pready = 1'b1;
assign busy = !idle;

wire [7:0] src_d = gpr[rd_reg];
wire [7:0] src_r = gpr[rr_reg];
wire c_old = flags_reg[`BFM_F_C];

////////////////////////////////////////////////////////////////////////////////
// shift results and the flag update they share
reg [7:0] sh_res;
reg sh_c;
reg is_shift;

always @* begin
    sh_res = src_d;
    sh_c = c_old;
    is_shift = 1'b0;
    case (op_reg)
        `BFM_OP_ROTL: begin
            sh_res = {src_d[6:0], c_old};
            sh_c = src_d[7];
            is_shift = 1'b1;
        end
        `BFM_OP_ROTR: begin
            sh_res = {c_old, src_d[7:1]};
            sh_c = src_d[0];
            is_shift = 1'b1;
        end
        `BFM_OP_ASHR: begin
            sh_res = {src_d[7], src_d[7:1]};
            sh_c = src_d[0];
            is_shift = 1'b1;
        end
        default: begin
            sh_res = src_d;
        end
    endcase
end

// one set/clear decoder per flag, bit order c n z s v t h
wire [6:0] fl_hit;
wire [6:0] fl_val;

bfm_flag_op #(
    .SET_OP(`BFM_OP_SET_C),
    .CLR_OP(`BFM_OP_CLR_C)
) i_flag_c (
    .op(op_reg),
    .hit(fl_hit[0]),
    .val(fl_val[0])
);
bfm_flag_op #(
    .SET_OP(`BFM_OP_SET_N),
    .CLR_OP(`BFM_OP_CLR_N)
) i_flag_n (
    .op(op_reg),
    .hit(fl_hit[1]),
    .val(fl_val[1])
);
bfm_flag_op #(
    .SET_OP(`BFM_OP_SET_Z),
    .CLR_OP(`BFM_OP_CLR_Z)
) i_flag_z (
    .op(op_reg),
    .hit(fl_hit[2]),
    .val(fl_val[2])
);
bfm_flag_op #(
    .SET_OP(`BFM_OP_SET_S),
    .CLR_OP(`BFM_OP_CLR_S)
) i_flag_s (
    .op(op_reg),
    .hit(fl_hit[3]),
    .val(fl_val[3])
);
bfm_flag_op #(
    .SET_OP(`BFM_OP_SET_V),
    .CLR_OP(`BFM_OP_CLR_V)
) i_flag_v (
    .op(op_reg),
    .hit(fl_hit[4]),
    .val(fl_val[4])
);
bfm_flag_op #(
    .SET_OP(`BFM_OP_SET_T),
    .CLR_OP(`BFM_OP_CLR_T)
) i_flag_t (
    .op(op_reg),
    .hit(fl_hit[5]),
    .val(fl_val[5])
);
bfm_flag_op #(
    .SET_OP(`BFM_OP_SET_H),
    .CLR_OP(`BFM_OP_CLR_H)
) i_flag_h (
    .op(op_reg),
    .hit(fl_hit[6]),
    .val(fl_val[6])
);

// flags start from their old value so only named ones move
always @* begin
    flags_next = flags_reg;
    if (state_reg == ST_EXEC) begin
        if (is_shift) begin
            flags_next[`BFM_F_C] = sh_c;
            flags_next[`BFM_F_Z] = (sh_res == 8'h00);
            flags_next[`BFM_F_N] = sh_res[7];
            flags_next[`BFM_F_V] = sh_res[7] ^ sh_c;
        end
        if (fl_hit[0]) flags_next[`BFM_F_C] = fl_val[0];
        if (fl_hit[1]) flags_next[`BFM_F_N] = fl_val[1];
        if (fl_hit[2]) flags_next[`BFM_F_Z] = fl_val[2];
        if (fl_hit[3]) flags_next[`BFM_F_S] = fl_val[3];
        if (fl_hit[4]) flags_next[`BFM_F_V] = fl_val[4];
        if (fl_hit[5]) flags_next[`BFM_F_T] = fl_val[5];
        if (fl_hit[6]) flags_next[`BFM_F_H] = fl_val[6];
        case (op_reg)
            `BFM_OP_BIT_TO_T: flags_next[`BFM_F_T] = src_d[bit_reg];
            default: flags_next[`BFM_F_I] = flags_reg[`BFM_F_I];
        endcase
    end else if (idle && wr_acc && (paddr == `BFM_FLAGS_OFS)) begin
        flags_next = pwdata[7:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer: one exec cycle, loads add a write-back cycle
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        state_reg <= ST_IDLE;
        op_reg <= `BFM_OP_NOP;
        rd_reg <= 5'h00;
        rr_reg <= 5'h00;
        bit_reg <= 3'h0;
        flags_reg <= `BFM_FLAGS_RST;
        mem_addr <= {ADDR_W{1'b0}};
        mem_rd <= 1'b0;
    end else begin
        flags_reg <= flags_next;
        mem_rd <= 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_wr) begin
                    op_reg <= cmd_op;
                    rd_reg <= pwdata[`BFM_CMD_RD];
                    rr_reg <= pwdata[`BFM_CMD_RR];
                    bit_reg <= pwdata[`BFM_CMD_BIT];
                    state_reg <= ST_EXEC;
                    if (cmd_load) begin
                        mem_addr <= x_ptr[ADDR_W-1:0];
                        mem_rd <= 1'b1;
                    end
                end
            end
            ST_EXEC: begin
                // memory answers in the strobe cycle; the data is written back in ST_LOAD
                if (op_reg == `BFM_OP_LDX || op_reg == `BFM_OP_LDXI) begin
                    state_reg <= ST_LOAD;
                end else begin
                    state_reg <= ST_IDLE;
                end
            end
            ST_LOAD: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// register file; no reset so it maps to plain memory
reg [7:0] load_data_reg;

always @(posedge clk) begin
    if (state_reg == ST_EXEC) begin
        load_data_reg <= mem_rdata;
        case (op_reg)
            `BFM_OP_ROTL, `BFM_OP_ROTR, `BFM_OP_ASHR: gpr[rd_reg] <= sh_res;
            `BFM_OP_SWAP: gpr[rd_reg] <= {src_d[3:0], src_d[7:4]};
            `BFM_OP_T_TO_BIT: begin
                gpr[rd_reg][bit_reg] <= flags_reg[`BFM_F_T];
            end
            `BFM_OP_COPY: gpr[rd_reg] <= src_r;
            `BFM_OP_PAIR_COPY: begin
                gpr[{rd_reg[4:1], 1'b0}] <= gpr[{rr_reg[4:1], 1'b0}];
                gpr[{rd_reg[4:1], 1'b1}] <= gpr[{rr_reg[4:1], 1'b1}];
            end
            default: load_data_reg <= mem_rdata;
        endcase
    end else if (state_reg == ST_LOAD) begin
        // loading into the x pair itself: the data wins over the bump
        if (op_reg == `BFM_OP_LDXI) begin
            gpr[`BFM_XL] <= x_inc[7:0];
            gpr[`BFM_XH] <= x_inc[15:8];
        end
        gpr[rd_reg] <= load_data_reg;
    end else if (idle && wr_acc && (paddr == `BFM_DATA_OFS)) begin
        gpr[sel_reg] <= pwdata[7:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb: read data captured in the setup cycle, zero wait states
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
        sel_reg <= 5'h00;
    end else begin
        if (setup) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            case (paddr)
                `BFM_CMD_OFS: prdata <= {24'h000000, 2'h0, op_reg};
                `BFM_FLAGS_OFS: prdata <= {23'h000000, busy, flags_reg};
                `BFM_SEL_OFS: prdata <= {27'h0000000, sel_reg};
                `BFM_DATA_OFS: prdata <= {24'h000000, gpr[sel_reg]};
                default: pslverr <= 1'b1;
            endcase
        end
        if (wr_acc && (paddr == `BFM_SEL_OFS)) begin
            sel_reg <= pwdata[4:0];
        end
    end
end

endmodule

////////////////////////////////////////////////////////////////////////////////
// decodes one set/clear pair for a single flag
module bfm_flag_op #(
    parameter SET_OP = 6'h00,
    parameter CLR_OP = 6'h00
) (
    input wire [5:0] op,
    output wire hit,
    output wire val
);

assign hit = (op == SET_OP) || (op == CLR_OP);
assign val = (op == SET_OP);

endmodule
